/* core/oft_regs.svh */
// Constants for the outbound frame transfer engine and its controller end.
`ifndef OFT_REGS_SVH
`define OFT_REGS_SVH

// ============================================================
// Instruction fields
`define OFT_OP_W        2
`define OFT_REF_W       18
`define OFT_HLEN_W      8
`define OFT_TYPE_W      4
`define OFT_OP_FREE     2'h0
`define OFT_OP_HDR      2'h1
`define OFT_OP_XMIT     2'h2
`define OFT_OP_RZV      2'h3
`define OFT_QW_PAD      4'h0

// ============================================================
// Descriptor layout: memory base, byte offsets from the descriptor start, header word indices
`define OFT_OCM_BASE    32'h0000_0000
`define OFT_DESC_PADDR  32'h0000_0000
`define OFT_DESC_BODY   32'h0000_0020
`define OFT_WORD_STEP   32'h0000_0004
`define OFT_LAST_WIDX   2'h3
`define OFT_PAY_WIDX    2'h1

// ============================================================
// Controller register offsets
`define OFT_REG_WORK    12'h000
`define OFT_REG_FREE    12'h004
`define OFT_REG_FRAME   12'h008
`define OFT_REG_STATUS  12'h00c

// ============================================================
// Controller register fields and reset values
`define OFT_WORK_REF_LSB  0
`define OFT_WORK_HLEN_LSB 18
`define OFT_WORK_TYPE_LSB 26
`define OFT_WORK_OP_LSB   30
`define OFT_VALID_BIT     31
`define OFT_LAST_BIT      30
`define OFT_FTYPE_LSB     8
`define OFT_WORK_RST      32'h0000_0000
`define OFT_CNT_W         16

`endif

/* core/oft_pkg.sv */
// Types shared by the outbound engine and its controller end.
package oft_pkg;

  // ============================================================
  // Engine states, one-hot.
  typedef enum logic [5:0]
  {
    OFT_IDLE  = 6'h01,
    OFT_FETCH = 6'h02,
    OFT_HDR   = 6'h04,
    OFT_PAY   = 6'h08,
    OFT_RZV   = 6'h10,
    OFT_REL   = 6'h20
  } oft_eng_state_t;

  // ============================================================
  // Whole state of the engine.
  typedef struct packed
  {
    oft_eng_state_t st;
    logic [1:0]     op;
    logic [3:0]     ftype;
    logic [17:0]    dref;
    logic [1:0]     wIdx;
    logic [31:0]    addr;
    logic [11:0]    hdrLeft;
    logic [31:0]    payAddr;
    logic [31:0]    payLeft;
    logic [31:0]    rz0;
    logic [31:0]    rz1;
    logic           have;
    logic [7:0]     data;
    logic           last;
  } oft_eng_t;

  // ============================================================
  // Whole state of the controller end.
  typedef struct packed
  {
    logic        instPend;
    logic [31:0] instWord;
    logic        freeValid;
    logic [17:0] freeRef;
    logic        byteValid;
    logic [7:0]  byteData;
    logic        byteLast;
    logic [3:0]  byteType;
    logic [15:0] frameCnt;
  } oft_ctl_t;

endpackage

/* core/oft_link_if.sv */
// Link between the outbound engine and the controller that feeds and drains it.
`timescale 1ns/1ps
interface oft_link_if;

  // Work-list instruction.
  logic        insValid;
  logic        insReady;
  logic [1:0]  insOp;
  logic [7:0]  insHdrLen;
  logic [3:0]  insType;
  logic [17:0] insRef;

  // Outbound frame byte stream.
  logic        txValid;
  logic        txReady;
  logic [7:0]  txData;
  logic        txLast;
  logic [3:0]  txType;

  // Descriptor return to the free-list.
  logic        relValid;
  logic        relReady;
  logic [17:0] relRef;

  modport engine
  (
    input  insValid, insOp, insHdrLen, insType, insRef, txReady, relReady,
    output insReady, txValid, txData, txLast, txType, relValid, relRef
  );

  modport client
  (
    output insValid, insOp, insHdrLen, insType, insRef, txReady, relReady,
    input  insReady, txValid, txData, txLast, txType, relValid, relRef
  );

endinterface

/* core/oft_engine.sv */
// Outbound frame transfer engine: runs work-list instructions, sends frames, frees descriptors.
//
// Contract
// [RL1] Opcode 0: send nothing, only free descriptor.
// [RL2] Opcode 0 length and type should be zero.
// [RL3] Opcode 0: descriptor contents never read.
// [RL4] Software fills free-list using opcode 0.
// [RL5] Opcode 1: frame is header only, no payload.
// [RL6] Header length in quadwords, within maximum.
// [RL7] Broken header length gives undefined behaviour.
// [RL8] Transmitting opcodes carry valid length and type.
// [RL9] Opcode 2: header then gathered payload, one frame.
// [RL10] Opcodes 2,3: zero header length means payload-only.
// [RL11] Payload address and length from first quadword.
// [RL12] Payload address may have any byte alignment.
// [RL13] Payload buffer flushed or uncached by software.
// [RL14] Payload length in bytes; zero means no fetch.
// [RL15] Software keeps length and address in range.
// [RL16] Opcode 2 ignores the rendezvous reference.
// [RL17] Opcode 3: transmit, then start rendezvous.
// [RL18] Rendezvous reference from second header quadword; the engine reads it from words 2,3, in the first.
// [RL19] Opcode 3: rendezvous first, then free descriptor.
// [RL20] Instructions run one at a time, in order.
// [RL21] Opcodes 1,2 free descriptor after transmission.
// [RL22] Frame whole: header, then payload, last marked.
`timescale 1ns/1ps
`include "oft_regs.svh"

module oft_engine
(
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Link to the controller end.
  oft_link_if.engine       link,
  // Memory read port, one aligned 32-bit word per request.
  output logic             memRd,
  output logic [31:0]      memAddr,
  input  wire logic        memAck,
  input  wire logic [31:0] memData,
  // Rendezvous channel.
  output logic             rzvValid,
  input  wire logic        rzvReady,
  output logic [31:0]      rzvWord0,
  output logic [31:0]      rzvWord1,
  // Status.
  output logic             busy
);

  oft_pkg::oft_eng_t s_q;
  oft_pkg::oft_eng_t s_d;

  // ============================================================
  // Helpers

  // Where an instruction goes once its frame has been sent.
  function automatic oft_pkg::oft_eng_state_t oftAfterFrame(input logic [1:0] op);
    if (op == `OFT_OP_RZV)
    begin
      return oft_pkg::OFT_RZV;
    end
    return oft_pkg::OFT_REL;
  endfunction

  // Descriptor address in the processor's address space.
  function automatic logic [31:0] oftDescAddr(input logic [17:0] dref);
    return `OFT_OCM_BASE + {14'h0, dref};
  endfunction

  // Picks one byte out of a little-endian word.
  function automatic logic [7:0] oftByteSel(input logic [31:0] w, input logic [1:0] lane);
    return w[{lane, 3'h0} +: 8];
  endfunction

  // ============================================================
  // Outputs

  // Memory is always addressed by word; the byte lane is picked on return, so any
  // payload alignment works at the cost of one read per byte.
  assign memAddr        = {s_q.addr[31:2], 2'h0};
  assign link.txData    = s_q.data;
  assign link.txLast    = s_q.last;
  assign link.txType    = s_q.ftype;
  assign link.relRef    = s_q.dref;
  assign rzvWord0       = s_q.rz0;
  assign rzvWord1       = s_q.rz1;
  assign busy           = (s_q.st != oft_pkg::OFT_IDLE);

  // A new instruction is only taken when idle, so they run one by one.
  assign link.insReady  = (s_q.st == oft_pkg::OFT_IDLE); // [RL20]
  assign memRd          = ((s_q.st == oft_pkg::OFT_FETCH)
                           || (s_q.st == oft_pkg::OFT_HDR)
                           || (s_q.st == oft_pkg::OFT_PAY))
                          && !s_q.have;
  assign link.txValid   = ((s_q.st == oft_pkg::OFT_HDR) || (s_q.st == oft_pkg::OFT_PAY))
                          && s_q.have;
  assign rzvValid       = (s_q.st == oft_pkg::OFT_RZV);
  assign link.relValid  = (s_q.st == oft_pkg::OFT_REL);

  // ============================================================
  // Next state

  // All sequencing lives here; the flip-flop process below only registers it.
  always_comb
  begin
    s_d = s_q;
    case (s_q.st)
      oft_pkg::OFT_IDLE:
      begin
        if (link.insValid)
        begin
          s_d.op      = link.insOp;
          s_d.ftype   = link.insType;
          s_d.dref    = link.insRef;
          s_d.hdrLeft = {link.insHdrLen, `OFT_QW_PAD};
          s_d.payLeft = 32'h0;
          s_d.wIdx    = 2'h0;
          s_d.have    = 1'b0;
          if (link.insOp == `OFT_OP_FREE)
          begin
            // No memory access at all for a plain free.
            s_d.st = oft_pkg::OFT_REL; // [RL1] [RL3]
          end
          else if (link.insOp == `OFT_OP_HDR)
          begin
            // Header-only frame: the payload reference is never read.
            s_d.st   = oft_pkg::OFT_HDR; // [RL5]
            s_d.addr = oftDescAddr(link.insRef) + `OFT_DESC_BODY;
          end
          else
          begin
            s_d.st   = oft_pkg::OFT_FETCH;
            s_d.addr = oftDescAddr(link.insRef) + `OFT_DESC_PADDR;
          end
        end
      end

      oft_pkg::OFT_FETCH:
      begin
        if (memAck)
        begin
          // Words 0,1 are the payload reference, words 2,3 the rendezvous one.
          case (s_q.wIdx)
            2'h0:    s_d.payAddr = memData; // [RL11]
            2'h1:    s_d.payLeft = memData; // [RL11] [RL14]
            2'h2:    s_d.rz0     = memData; // [RL18]
            default: s_d.rz1     = memData; // [RL18]
          endcase
          // Opcode 2 stops after the payload reference and never looks further.
          if (((s_q.wIdx == `OFT_PAY_WIDX) && (s_q.op != `OFT_OP_RZV))
              || (s_q.wIdx == `OFT_LAST_WIDX)) // [RL16]
          begin
            if (s_q.hdrLeft != 12'h0)
            begin
              s_d.st   = oft_pkg::OFT_HDR; // [RL9]
              s_d.addr = oftDescAddr(s_q.dref) + `OFT_DESC_BODY;
            end
            else if (s_d.payLeft != 32'h0)
            begin
              s_d.st   = oft_pkg::OFT_PAY; // [RL10]
              s_d.addr = s_d.payAddr;
            end
            else
            begin
              // Nothing to send and nothing fetched.
              s_d.st = oftAfterFrame(s_q.op); // [RL14]
            end
          end
          else
          begin
            s_d.wIdx = s_q.wIdx + 2'h1;
            s_d.addr = s_q.addr + `OFT_WORD_STEP;
          end
        end
      end

      oft_pkg::OFT_HDR,
      oft_pkg::OFT_PAY:
      begin
        if (!s_q.have)
        begin
          if (memAck)
          begin
            s_d.data = oftByteSel(memData, s_q.addr[1:0]); // [RL12]
            s_d.have = 1'b1;
            // Last byte of the header only ends the frame when no payload follows.
            if (s_q.st == oft_pkg::OFT_HDR)
            begin
              s_d.last = (s_q.hdrLeft == 12'h1)
                         && ((s_q.op == `OFT_OP_HDR) || (s_q.payLeft == 32'h0)); // [RL22]
            end
            else
            begin
              s_d.last = (s_q.payLeft == 32'h1); // [RL22]
            end
          end
        end
        else if (link.txReady)
        begin
          s_d.have = 1'b0;
          s_d.addr = s_q.addr + 32'h1;
          if (s_q.st == oft_pkg::OFT_HDR)
          begin
            s_d.hdrLeft = s_q.hdrLeft - 12'h1;
            if (s_q.hdrLeft == 12'h1)
            begin
              // Payload bytes follow the header in the same frame.
              if ((s_q.op != `OFT_OP_HDR) && (s_q.payLeft != 32'h0))
              begin
                s_d.st   = oft_pkg::OFT_PAY; // [RL9] [RL22]
                s_d.addr = s_q.payAddr;
              end
              else
              begin
                s_d.st = oftAfterFrame(s_q.op);
              end
            end
          end
          else
          begin
            s_d.payLeft = s_q.payLeft - 32'h1;
            s_d.payAddr = s_q.payAddr + 32'h1;
            if (s_q.payLeft == 32'h1)
            begin
              s_d.st = oftAfterFrame(s_q.op); // [RL17]
            end
          end
        end
      end

      oft_pkg::OFT_RZV:
      begin
        // The rendezvous is posted after the frame's last byte was taken, or straight after the fetch when the frame is empty.
        if (rzvReady)
        begin
          s_d.st = oft_pkg::OFT_REL; // [RL17] [RL19]
        end
      end

      oft_pkg::OFT_REL:
      begin
        if (link.relReady)
        begin
          s_d.st = oft_pkg::OFT_IDLE; // [RL21] [RL20]
        end
      end

      default:
      begin
        s_d.st = oft_pkg::OFT_IDLE;
      end
    endcase
  end

  // ============================================================
  // State register

  // Reset loads the idle state code and clears every other field to zero.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      s_q <= '{st: oft_pkg::OFT_IDLE, default: '0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

endmodule

/* core/oft_client.sv */
// Controller end: APB registers that post instructions and drain frames and free descriptors.
`timescale 1ns/1ps
`include "oft_regs.svh"

module oft_client
(
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // APB slave.
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Link to the engine.
  oft_link_if.client       link
);

  oft_pkg::oft_ctl_t c_q;
  oft_pkg::oft_ctl_t c_d;
  logic              access;
  logic              mapped;

  // ============================================================
  // Link side

  // Fields go to the engine exactly as software wrote them; lengths and types are
  // not checked, so a bad header length reaches the engine unchanged.
  assign link.insValid  = c_q.instPend;
  assign link.insRef    = c_q.instWord[`OFT_WORK_REF_LSB +: 18];  // [RL4]
  assign link.insHdrLen = c_q.instWord[`OFT_WORK_HLEN_LSB +: 8];  // [RL6] [RL7]
  assign link.insType   = c_q.instWord[`OFT_WORK_TYPE_LSB +: 4];  // [RL2] [RL8]
  assign link.insOp     = c_q.instWord[`OFT_WORK_OP_LSB +: 2];
  // Single holding slots; a full slot stalls the engine until software reads it.
  assign link.txReady   = !c_q.byteValid;
  assign link.relReady  = !c_q.freeValid;

  // ============================================================
  // APB decode

  // A write to the work-list stalls while the previous instruction waits, which
  // keeps the posted order intact.
  assign access  = psel && penable;
  assign mapped  = (paddr == `OFT_REG_WORK) || (paddr == `OFT_REG_FREE)
                   || (paddr == `OFT_REG_FRAME) || (paddr == `OFT_REG_STATUS);
  assign pready  = !(psel && pwrite && (paddr == `OFT_REG_WORK) && c_q.instPend); // [RL20]
  assign pslverr = access && !mapped;

  // Read data; the buffer address is not cache-managed here, software owns that.
  always_comb
  begin
    prdata = 32'h0;
    case (paddr)
      `OFT_REG_FREE:
      begin
        prdata[`OFT_VALID_BIT] = c_q.freeValid;
        prdata[17:0]           = c_q.freeRef; // [RL13] [RL15]
      end
      `OFT_REG_FRAME:
      begin
        prdata[`OFT_VALID_BIT]         = c_q.byteValid;
        prdata[`OFT_LAST_BIT]          = c_q.byteLast;
        prdata[`OFT_FTYPE_LSB +: 4]    = c_q.byteType;
        prdata[7:0]                    = c_q.byteData;
      end
      `OFT_REG_STATUS:
      begin
        prdata[0]     = c_q.instPend;
        prdata[1]     = c_q.freeValid;
        prdata[2]     = c_q.byteValid;
        prdata[31:16] = c_q.frameCnt;
      end
      default:
      begin
        prdata = 32'h0;
      end
    endcase
  end

  // ============================================================
  // Next state

  // Slots are loaded only when empty; a read pops the frame or free slot even when empty,
  // and a load in the same cycle wins, so the slot is left full.
  always_comb
  begin
    c_d = c_q;
    if (link.insReady && c_q.instPend)
    begin
      c_d.instPend = 1'b0;
    end
    if (access && pready && pwrite && (paddr == `OFT_REG_WORK))
    begin
      c_d.instPend = 1'b1;
      c_d.instWord = pwdata;
    end
    if (link.relValid && !c_q.freeValid)
    begin
      c_d.freeValid = 1'b1;
      c_d.freeRef   = link.relRef;
    end
    else if (access && !pwrite && (paddr == `OFT_REG_FREE))
    begin
      c_d.freeValid = 1'b0;
    end
    if (link.txValid && !c_q.byteValid)
    begin
      c_d.byteValid = 1'b1;
      c_d.byteData  = link.txData;
      c_d.byteLast  = link.txLast;
      c_d.byteType  = link.txType;
      if (link.txLast)
      begin
        c_d.frameCnt = c_q.frameCnt + 16'h1;
      end
    end
    else if (access && !pwrite && (paddr == `OFT_REG_FRAME))
    begin
      c_d.byteValid = 1'b0;
    end
  end

  // ============================================================
  // State register
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      c_q <= '{instWord: `OFT_WORK_RST, default: '0};
    end
    else
    begin
      c_q <= c_d;
    end
  end

endmodule

/* tb/oft_link_chk.sv */
// Link checker for the outbound engine and its controller end.
`timescale 1ns/1ps
`include "oft_regs.svh"
module oft_link_chk
(
  // Clock and reset.
  input wire logic        sys_clk,
  input wire logic        rst,
  // Instruction channel.
  input wire logic        insValid,
  input wire logic        insReady,
  input wire logic [1:0]  insOp,
  input wire logic [7:0]  insHdrLen,
  input wire logic [3:0]  insType,
  input wire logic [17:0] insRef,
  // Frame channel.
  input wire logic        txValid,
  input wire logic        txReady,
  input wire logic [7:0]  txData,
  input wire logic        txLast,
  input wire logic [3:0]  txType,
  // Release channel.
  input wire logic        relValid,
  input wire logic        relReady,
  input wire logic [17:0] relRef
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // ============================================================
  // Helper state
  logic        take;
  logic [1:0]  opQ;
  logic [7:0]  hlenQ;
  logic [3:0]  typeQ;
  logic [17:0] refQ;
  logic [15:0] cntQ;

  // Fields of the running instruction, and bytes handed over since it was taken.
  assign take = insValid && insReady;
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      opQ   <= 2'h0;
      hlenQ <= 8'h0;
      typeQ <= 4'h0;
      refQ  <= 18'h0;
      cntQ  <= 16'h0;
    end
    else if (take)
    begin
      opQ   <= insOp;
      hlenQ <= insHdrLen;
      typeQ <= insType;
      refQ  <= insRef;
      cntQ  <= 16'h0;
    end
    else if (txValid && txReady)
    begin
      cntQ <= cntQ + 16'h1;
    end
  end

  // ============================================================
  // Assertions
  chk_tx_hold: assert property (txValid && !txReady |=> txValid && $stable(txData) && $stable(txLast))
    else $error("frame byte changed before it was taken");
  chk_rel_hold: assert property (relValid && !relReady |=> relValid && $stable(relRef))
    else $error("descriptor return dropped before it was taken");
  chk_rel_ref: assert property (relValid |-> relRef == refQ)
    else $error("returned descriptor is not the one taken");
  chk_free_release: assert property (take && insOp == `OFT_OP_FREE |-> ##[1:8] relValid)
    else $error("free instruction did not return its descriptor");
  chk_free_silent: assert property (txValid |-> opQ != `OFT_OP_FREE)
    else $error("free instruction produced a frame byte");
  chk_one_at_time: assert property (txValid || relValid |-> !insReady)
    else $error("engine ready while an instruction is running");
  chk_idle_after: assert property (relValid && relReady |=> insReady)
    else $error("engine not idle after descriptor return");
  chk_frame_type: assert property (txValid |-> txType == typeQ)
    else $error("frame type differs from the instruction");
  chk_hdr_count: assert property (txValid && txLast && opQ == `OFT_OP_HDR
    |-> cntQ == {4'h0, hlenQ, 4'h0} - 16'h1)
    else $error("header-only frame has wrong byte count");
  chk_last_once: assert property (txValid && txReady && txLast |=> !txValid [*2])
    else $error("byte offered right after the last byte");

  // Main scenarios reached.
  cover property (take && insOp == `OFT_OP_RZV);
  cover property (txValid && txReady && txLast);
  cover property (relValid && !relReady);
endmodule

/* tb/tb_top.sv */
// Self-checking bench: APB controller end and engine joined by the link.
`timescale 1ns/1ps
`include "oft_regs.svh"
module tb_top;
  // ============================================================
  // Signals
  logic        sys_clk  = 1'b0;
  logic        rst      = 1'b1;
  logic [11:0] paddr    = 12'h0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [31:0] pwdata   = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        memRd;
  logic [31:0] memAddr;
  logic        memAck   = 1'b0;
  logic [31:0] memData  = 32'h0;
  logic        rzvValid;
  logic        rzvReady = 1'b0;
  logic [31:0] rzvWord0;
  logic [31:0] rzvWord1;
  logic [31:0] rzvW0;
  logic [31:0] rzvW1;
  logic        busy;
  logic [1:0]  tick     = 2'h0;
  logic [7:0]  memB [0:4095];
  int          err_total, samples_checked, cyc, rdCnt, rzvCnt, rzvLast, lastCnt, relRzv;

  oft_link_if link();
  oft_client oft_client_inst(.sys_clk(sys_clk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  oft_engine oft_engine_inst(.sys_clk(sys_clk), .rst(rst), .link(link), .memRd(memRd),
    .memAddr(memAddr), .memAck(memAck), .memData(memData), .rzvValid(rzvValid),
    .rzvReady(rzvReady), .rzvWord0(rzvWord0), .rzvWord1(rzvWord1), .busy(busy));
  oft_link_chk chk_inst(.sys_clk(sys_clk), .rst(rst), .insValid(link.insValid),
    .insReady(link.insReady), .insOp(link.insOp), .insHdrLen(link.insHdrLen),
    .insType(link.insType), .insRef(link.insRef), .txValid(link.txValid),
    .txReady(link.txReady), .txData(link.txData), .txLast(link.txLast),
    .txType(link.txType), .relValid(link.relValid), .relReady(link.relReady),
    .relRef(link.relRef));

  // Clock at 200 MHz.
  always #2.5 sys_clk = ~sys_clk;

  // Memory answers every other try so latency varies; rendezvous taken one cycle late.
  always @(posedge sys_clk)
  begin
    tick     <= tick + 2'h1;
    memAck   <= memRd && !memAck && tick[0];
    memData  <= {memB[{memAddr[11:2], 2'h3}], memB[{memAddr[11:2], 2'h2}],
                 memB[{memAddr[11:2], 2'h1}], memB[{memAddr[11:2], 2'h0}]};
    rzvReady <= rzvValid && !rzvReady;
    if (memRd && memAck) rdCnt <= rdCnt + 1;
    if (link.txValid && link.txReady && link.txLast) lastCnt <= lastCnt + 1;
    if (link.relValid && link.relReady) relRzv <= rzvCnt;
    if (rzvValid && rzvReady)
    begin
      rzvCnt  <= rzvCnt + 1;
      rzvW0   <= rzvWord0;
      rzvW1   <= rzvWord1;
      rzvLast <= lastCnt;
    end
  end

  // A hang ends the run as a failure.
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      cmp(32'h0, 32'h1, "run timeout");
      end_of_test();
    end
  end

  // ============================================================
  // Shared tasks
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
    begin
      $display("SIMULATION PASSED");
    end
    else
    begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // One APB transfer; the master waits on pready, bounded.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int n = 0;
    @(posedge sys_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Answer is read settled, before the completing edge pops a slot or sets pending.
    @(negedge sys_clk);
    while (pready !== 1'b1 && n < 200)
    begin
      @(negedge sys_clk);
      n++;
    end
    if (n == 200) cmp(32'h0, 32'h1, "apb wait");
    rd = prdata;
    er = pslverr;
    @(posedge sys_clk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Reads a slot register until its valid bit shows.
  task automatic poll(input logic [11:0] a, output logic [31:0] rd);
    logic er;
    int   n = 0;
    rd = 32'h0;
    while (rd[31] !== 1'b1 && n < 100)
    begin
      apb(1'b0, a, 32'h0, rd, er);
      n++;
    end
  endtask

  task automatic post(input logic [1:0] op, input logic [7:0] hl, input logic [3:0] ty,
                      input logic [17:0] dr);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, `OFT_REG_WORK, {op, ty, hl, dr}, rd, er);
  endtask

  // Descriptor header: payload address, payload length, two rendezvous words.
  task automatic setd(input int d, input logic [31:0] pa, input logic [31:0] pl,
                      input logic [31:0] r0, input logic [31:0] r1);
    for (int i = 0; i < 4; i++)
    begin
      memB[d + i]      = pa[8 * i +: 8];
      memB[d + 4 + i]  = pl[8 * i +: 8];
      memB[d + 8 + i]  = r0[8 * i +: 8];
      memB[d + 12 + i] = r1[8 * i +: 8];
    end
  endtask

  task automatic chk_free(input logic [17:0] dr);
    logic [31:0] rd;
    poll(`OFT_REG_FREE, rd);
    cmp(rd & 32'h8003ffff, {1'b1, 13'h0, dr}, "free ref");
  endtask

  // Expected frame: body header bytes first, then payload bytes, last flag on the end.
  task automatic chk_frame(input int dr, input int hl, input int pa, input int pl,
                           input logic [3:0] ty);
    logic [7:0]  e[$];
    logic [31:0] rd;
    for (int i = 0; i < hl * 16; i++) e.push_back(memB[dr + 32 + i]);
    for (int i = 0; i < pl; i++) e.push_back(memB[pa + i]);
    foreach (e[i])
    begin
      poll(`OFT_REG_FRAME, rd);
      cmp(rd & 32'hc0000fff, {1'b1, i == e.size() - 1, 18'h0, ty, e[i]}, "frame byte");
    end
  endtask

  // ============================================================
  // Scenarios
  task automatic t_free();
    int r = rdCnt;
    post(`OFT_OP_FREE, 8'h0, 4'h0, 18'h100);
    post(`OFT_OP_FREE, 8'h0, 4'h0, 18'h200);
    post(`OFT_OP_FREE, 8'h0, 4'h0, 18'h300);
    chk_free(18'h100);
    chk_free(18'h200);
    chk_free(18'h300);
    cmp(32'(rdCnt - r), 32'h0, "free reads");
  endtask

  task automatic t_hdr_order();
    int r = rdCnt;
    post(`OFT_OP_HDR, 8'h1, 4'h5, 18'h100);
    post(`OFT_OP_FREE, 8'h0, 4'h0, 18'h200);
    chk_frame(32'h100, 1, 0, 0, 4'h5);
    chk_free(18'h100);
    chk_free(18'h200);
    cmp(32'(rdCnt - r), 32'd16, "header reads");
  endtask

  task automatic t_xmit();
    int z = rzvCnt;
    setd(32'h200, 32'h803, 32'h6, 32'hdead_0001, 32'hdead_0002);
    post(`OFT_OP_XMIT, 8'h1, 4'h9, 18'h200);
    chk_frame(32'h200, 1, 32'h803, 6, 4'h9);
    chk_free(18'h200);
    cmp(32'(rzvCnt - z), 32'h0, "no rendezvous");
  endtask

  task automatic t_zero();
    logic [31:0] rd;
    logic        er;
    int          r;
    setd(32'h300, 32'h902, 32'h3, 32'h0, 32'h0);
    post(`OFT_OP_XMIT, 8'h0, 4'h2, 18'h300);
    chk_frame(32'h300, 0, 32'h902, 3, 4'h2);
    chk_free(18'h300);
    setd(32'h300, 32'h900, 32'h0, 32'h0, 32'h0);
    r = rdCnt;
    post(`OFT_OP_XMIT, 8'h0, 4'h2, 18'h300);
    chk_free(18'h300);
    cmp(32'(rdCnt - r), 32'h2, "empty frame reads");
    apb(1'b0, `OFT_REG_FRAME, 32'h0, rd, er);
    cmp({31'h0, rd[31]}, 32'h0, "empty frame bytes");
  endtask

  task automatic t_rzv();
    int z = rzvCnt;
    setd(32'h400, 32'ha01, 32'h2, 32'h1234_5678, 32'h9abc_def0);
    post(`OFT_OP_RZV, 8'h1, 4'h3, 18'h400);
    chk_frame(32'h400, 1, 32'ha01, 2, 4'h3);
    chk_free(18'h400);
    cmp(32'(rzvCnt - z), 32'h1, "rendezvous count");
    cmp(rzvW0, 32'h1234_5678, "rendezvous word 0");
    cmp(rzvW1, 32'h9abc_def0, "rendezvous word 1");
    cmp(32'(rzvLast), 32'(lastCnt), "rendezvous after frame");
    cmp(32'(relRzv), 32'(rzvCnt), "rendezvous before return");
  endtask

  // Unmapped access is refused; status counts four completed frames, engine idle.
  task automatic t_regs();
    logic [31:0] rd;
    logic        er;
    apb(1'b0, 12'h010, 32'h0, rd, er);
    cmp({er, rd[30:0]}, 32'h8000_0000, "unmapped read");
    apb(1'b0, `OFT_REG_STATUS, 32'h0, rd, er);
    cmp(rd, 32'h0004_0000, "status");
    cmp({31'h0, busy}, 32'h0, "engine idle at end");
  endtask

  // ============================================================
  // Main sequence
  initial
  begin
    for (int i = 0; i < 4096; i++) memB[i] = 8'(i * 7 + 3);
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    t_free();
    t_hdr_order();
    t_xmit();
    t_zero();
    t_rzv();
    t_regs();
    end_of_test();
  end
endmodule
